// [shared/olhi_pkg.sv]
// Purpose: shared constants and types for the display host link
// Assumes: 100 MHz system clock on both ends
// Notes:   mode select pins are {hi, lo}
package olhi_pkg;
  typedef enum logic [1:0] {OLHI_P6800, OLHI_P8080, OLHI_SPI, OLHI_I2C} olhi_mode_t;

  localparam int          CLK_NS        = 10;
  localparam int          LINK_HALF_NS  = 80;
  localparam int          LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0]  NOP_CMD       = 8'hE3;
  localparam logic [6:0]  I2C_ADDR_BASE = 7'h3C;
  localparam int          CTRL_CO_BIT   = 7;
  localparam int          CTRL_DC_BIT   = 6;
  localparam logic [7:0]  CTRL_CMD      = 8'h00;
  localparam logic [7:0]  CTRL_DATA     = 8'h40;
  localparam int          SCLK_BIT      = 0;
  localparam int          SERIAL_DATA_IN_BIT      = 1;
  localparam int          ACK_BIT       = 2;

  localparam logic [15:0] SYNC_RST      = 16'h0FFF;

  localparam logic [5:0]  LAST_PAR      = 6'h03;
  localparam logic [5:0]  LAST_SPI      = 6'h11;
  localparam logic [5:0]  LAST_I2C      = 6'h3A;

  localparam logic [7:0]  CMD_DISP_OFF  = 8'hAE;
  localparam logic [7:0]  CMD_DISP_ON   = 8'hAF;
  localparam logic [7:0]  CMD_MUX       = 8'hA8;
  localparam logic [7:0]  MUX_32        = 8'h1F;
  localparam logic [7:0]  CMD_PRECHG    = 8'hD9;
  localparam logic [7:0]  PRECHG_VAL    = 8'hD2;
  localparam logic [7:0]  CMD_ADDR_MODE = 8'h20;
  localparam logic [7:0]  ADDR_HORIZ    = 8'h00;
  localparam logic [9:0]  INIT_CMDS     = 10'h007;
  localparam logic [9:0]  INIT_FILL     = 10'h200;
  localparam logic [9:0]  INIT_LAST     = 10'h207;

  function automatic olhi_mode_t modeOf(input logic hi, input logic lo);
    if (hi && !lo) modeOf = OLHI_P6800;
    else if (hi) modeOf = OLHI_P8080;
    else if (!lo) modeOf = OLHI_SPI;
    else modeOf = OLHI_I2C;
  endfunction
endpackage

// [shared/olhi_if.sv]
// Purpose: pins between host and display controller
// Assumes: undriven lines pull high
// Notes:   in I2C mode lines 1 and 2 are one wired-and line
`timescale 1ns/1ns
interface olhi_if;
  logic       resetN;
  logic       csN;
  logic       dc;
  logic       rwWrN;
  logic       eRdN;
  logic       selHi;
  logic       selLo;
  logic       addrLsb;
  logic [7:0] hostDbOut;
  logic [7:0] hostDbOe;
  logic [7:0] devDbOut;
  logic [7:0] devDbOe;
  logic [7:0] db;

  logic [7:0] lvl;
  logic       i2cJoin;
  always_comb begin
    lvl     = (~hostDbOe | hostDbOut) & (~devDbOe | devDbOut);
    i2cJoin = !selHi && selLo;
    db      = lvl;
    if (i2cJoin) begin
      db[1] = lvl[1] & lvl[2];
      db[2] = lvl[1] & lvl[2];
    end
  end

  modport host (output resetN, output csN, output dc, output rwWrN, output eRdN, output selHi,
                output selLo, output addrLsb, output hostDbOut, output hostDbOe, input db);
  modport dev  (input resetN, input csN, input dc, input rwWrN, input eRdN, input selHi,
                input selLo, input addrLsb, output devDbOut, output devDbOe, input db);
endinterface

// [core/olhi_device.sv]
// Purpose: display controller end of the host link, all four link modes
// Assumes: every pin passes two flops; strobe phases last at least 6 clk_sys cycles
// Notes:   bytes leave on wrValid; reads are served from statusByte / readByte
`timescale 1ns/1ns
module olhi_device import olhi_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  olhi_if.dev             link,
  output logic            wrValid,
  output logic            wrIsData,
  output logic [7:0]      wrByte,
  output logic            rdDone,
  output logic            rdIsData,
  input  wire logic [7:0] statusByte,
  input  wire logic [7:0] readByte,
  output olhi_mode_t      mode
);
  typedef enum {I_IDLE, I_ADDR, I_CTRL, I_BYTE} olhi_i2c_t;

  logic [15:0] syncA_q;
  logic [15:0] syncB_q;
  logic [15:0] prev_q;
  logic [15:0] rise;
  logic [15:0] fall;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= SYNC_RST;
      syncB_q <= SYNC_RST;
      prev_q  <= SYNC_RST;
    end else begin
      syncA_q <= {link.db, link.eRdN, link.rwWrN, link.dc, link.csN, link.addrLsb,
                  link.selLo, link.selHi, link.resetN};
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end
  assign rise = syncB_q & ~prev_q;
  assign fall = ~syncB_q & prev_q;

  logic       pinRst;
  logic       csN;
  logic       dc;
  logic       rwWrN;
  logic       eRdN;
  logic       addrLsb;
  logic [7:0] db;
  assign pinRst  = !syncB_q[0];
  assign addrLsb = syncB_q[3];
  assign csN     = syncB_q[4];
  assign dc      = syncB_q[5];
  assign rwWrN   = syncB_q[6];
  assign eRdN    = syncB_q[7];
  assign db      = syncB_q[15:8];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) mode <= OLHI_SPI;
    else mode <= modeOf(syncB_q[1], syncB_q[2]);
  end

  // serial shifter
  logic [2:0] spiCnt_q;
  logic [6:0] spiSh_q;
  logic       spiTake;
  assign spiTake = mode == OLHI_SPI && !csN && rise[8 + SCLK_BIT] && spiCnt_q == 3'h7;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spiCnt_q <= 3'h0;
      spiSh_q  <= 7'h00;
    end else if (pinRst || csN || mode != OLHI_SPI) begin
      spiCnt_q <= 3'h0;
    end else if (rise[8 + SCLK_BIT]) begin
      spiSh_q  <= {spiSh_q[5:0], db[SERIAL_DATA_IN_BIT]};
      spiCnt_q <= spiCnt_q + 3'h1;
    end
  end

  // I2C target, write only
  olhi_i2c_t  i2cSt_q;
  logic [3:0] i2cCnt_q;
  logic [6:0] i2cSh_q;
  logic       ackPh_q;
  logic       ackQ;
  logic       accQ;
  logic       i2cDc_q;
  logic       i2cCo_q;
  logic       scl;
  logic       sda;
  logic       sclRise;
  logic       sclFall;
  logic [7:0] i2cFull;
  logic       i2cTake;
  assign scl     = db[SCLK_BIT];
  assign sda     = db[SERIAL_DATA_IN_BIT];
  assign sclRise = mode == OLHI_I2C && rise[8 + SCLK_BIT];
  assign sclFall = mode == OLHI_I2C && fall[8 + SCLK_BIT];
  assign i2cFull = {i2cSh_q, sda};
  assign i2cTake = sclRise && i2cSt_q == I_BYTE && i2cCnt_q == 4'h7;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      i2cSt_q  <= I_IDLE;
      i2cCnt_q <= 4'h0;
      i2cSh_q  <= 7'h00;
      ackPh_q  <= 1'b0;
      ackQ     <= 1'b0;
      accQ     <= 1'b0;
      i2cDc_q  <= 1'b0;
      i2cCo_q  <= 1'b0;
    end else if (pinRst || mode != OLHI_I2C) begin
      i2cSt_q  <= I_IDLE;
      i2cCnt_q <= 4'h0;
      ackPh_q  <= 1'b0;
      ackQ     <= 1'b0;
    end else if (scl && fall[8 + SERIAL_DATA_IN_BIT]) begin
      i2cSt_q  <= I_ADDR;
      i2cCnt_q <= 4'h0;
      ackPh_q  <= 1'b0;
      ackQ     <= 1'b0;
    end else if (scl && rise[8 + SERIAL_DATA_IN_BIT]) begin
      i2cSt_q  <= I_IDLE;
      ackQ     <= 1'b0;
    end else if (sclRise && i2cSt_q != I_IDLE && i2cCnt_q < 4'h8) begin
      i2cSh_q  <= i2cFull[6:0];
      i2cCnt_q <= i2cCnt_q + 4'h1;
      if (i2cCnt_q == 4'h7) begin
        case (i2cSt_q)
          I_ADDR: accQ <= i2cFull[7:1] == {I2C_ADDR_BASE[6:1], addrLsb} && !i2cFull[0];
          I_CTRL: begin
            accQ    <= 1'b1;
            i2cDc_q <= i2cFull[CTRL_DC_BIT];
            i2cCo_q <= i2cFull[CTRL_CO_BIT];
          end
          default: accQ <= 1'b1;
        endcase
      end
    end else if (sclFall && i2cCnt_q == 4'h8) begin
      if (!ackPh_q) begin
        ackPh_q <= 1'b1;
        ackQ    <= accQ;
      end else begin
        ackPh_q  <= 1'b0;
        ackQ     <= 1'b0;
        i2cCnt_q <= 4'h0;
        case (i2cSt_q)
          I_ADDR:  i2cSt_q <= accQ ? I_CTRL : I_IDLE;
          I_CTRL:  i2cSt_q <= I_BYTE;
          I_BYTE:  i2cSt_q <= i2cCo_q ? I_CTRL : I_BYTE;
          default: i2cSt_q <= I_IDLE;
        endcase
      end
    end
  end

  // parallel strobes
  logic wr80;
  logic rd80;
  logic fallE68;
  logic takeWr;
  logic takeDc;
  logic [7:0] takeByte;
  logic rdFin;
  logic rdOe;
  assign fallE68 = mode == OLHI_P6800 && !csN && fall[7];
  assign wr80 = mode == OLHI_P8080 && ((rise[6] && !csN) || (rise[4] && !rwWrN && eRdN));
  assign rd80 = mode == OLHI_P8080 && ((rise[7] && !csN) || (rise[4] && !eRdN && rwWrN));
  assign rdOe = !csN && ((mode == OLHI_P6800 && rwWrN && eRdN) || (mode == OLHI_P8080 && !eRdN && rwWrN));

  always_comb begin
    takeWr   = 1'b0;
    takeDc   = dc;
    takeByte = db;
    rdFin    = 1'b0;
    if (fallE68) begin
      takeWr = !rwWrN;
      rdFin  = rwWrN;
    end else if (wr80) begin
      takeWr = 1'b1;
    end else if (rd80) begin
      rdFin  = 1'b1;
    end else if (spiTake) begin
      takeWr   = 1'b1;
      takeByte = {spiSh_q, db[SERIAL_DATA_IN_BIT]};
    end else if (i2cTake) begin
      takeWr   = 1'b1;
      takeDc   = i2cDc_q;
      takeByte = i2cFull;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrValid  <= 1'b0;
      wrIsData <= 1'b0;
      wrByte   <= 8'h00;
      rdDone   <= 1'b0;
      rdIsData <= 1'b0;
    end else begin
      wrValid <= takeWr && !pinRst && !(!takeDc && takeByte == NOP_CMD);
      rdDone  <= rdFin && !pinRst;
      if (takeWr) begin
        wrIsData <= takeDc;
        wrByte   <= takeByte;
      end
      if (rdFin) rdIsData <= dc;
    end
  end

  // pin drive: read data or I2C acknowledge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      link.devDbOut <= 8'h00;
      link.devDbOe  <= 8'h00;
    end else if (rdOe && !pinRst) begin
      link.devDbOut <= dc ? readByte : statusByte;
      link.devDbOe  <= 8'hFF;
    end else begin
      link.devDbOut <= 8'h00;
      link.devDbOe  <= {5'h00, ackQ, 2'h0};
    end
  end
endmodule // olhi_device

// [core/olhi_host.sv]
// Purpose: host end driving the display link in any of the four modes
// Assumes: mode input stays stable while busy
// Notes:   reads are refused on the two serial modes; optional power-up sequence
`timescale 1ns/1ns
module olhi_host import olhi_pkg::*; #(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  olhi_if.host            link,
  input  olhi_mode_t      modeSel,
  input  wire logic       addrLsbSel,
  input  wire logic       devResetReq,
  input  wire logic       initStart,
  output logic            initBusy,
  input  wire logic       reqValid,
  input  wire logic       reqRead,
  input  wire logic       reqIsData,
  input  wire logic [7:0] reqByte,
  output logic            reqReady,
  output logic            rspValid,
  output logic [7:0]      rspByte
);
  logic [7:0] dbA_q;
  logic [7:0] dbB_q;
  logic [7:0] divCnt_q;
  logic       tick;
  logic       busy_q;
  logic [5:0] step_q;
  logic       opRead_q;
  logic       opDc_q;
  logic [7:0] opByte_q;
  logic [9:0] initIdx_q;
  logic       serial;
  logic       initGo;
  logic       userGo;

  function automatic logic [8:0] initItem(input logic [9:0] idx);
    if (idx == 10'h000) initItem = {1'b0, CMD_DISP_OFF};
    else if (idx == 10'h001) initItem = {1'b0, CMD_MUX};
    else if (idx == 10'h002) initItem = {1'b0, MUX_32};
    else if (idx == 10'h003) initItem = {1'b0, CMD_PRECHG};
    else if (idx == 10'h004) initItem = {1'b0, PRECHG_VAL};
    else if (idx == 10'h005) initItem = {1'b0, CMD_ADDR_MODE};
    else if (idx == 10'h006) initItem = {1'b0, ADDR_HORIZ};
    else if (idx < INIT_LAST) initItem = {1'b1, 8'h00};
    else initItem = {1'b0, CMD_DISP_ON};
  endfunction

  function automatic logic [5:0] lastOf(input olhi_mode_t m);
    if (m == OLHI_SPI) lastOf = LAST_SPI;
    else if (m == OLHI_I2C) lastOf = LAST_I2C;
    else lastOf = LAST_PAR;
  endfunction

  logic [8:0] initNow;
  assign initNow  = initItem(initIdx_q);
  assign serial   = modeSel == OLHI_SPI || modeSel == OLHI_I2C;
  assign tick     = divCnt_q == 8'(HALF_CYC - 1);
  assign reqReady = !busy_q && !initBusy;
  assign initGo   = !busy_q && initBusy;
  assign userGo   = reqValid && reqReady && !(reqRead && serial);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dbA_q    <= 8'hFF;
      dbB_q    <= 8'hFF;
      divCnt_q <= 8'h00;
    end else begin
      dbA_q    <= link.db;
      dbB_q    <= dbA_q;
      divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      initBusy  <= 1'b0;
      initIdx_q <= 10'h000;
    end else if (!initBusy && initStart) begin
      initBusy  <= 1'b1;
      initIdx_q <= 10'h000;
    end else if (initGo) begin
      initIdx_q <= initIdx_q + 10'h001;
      if (initIdx_q == INIT_LAST) initBusy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_q   <= 1'b0;
      step_q   <= 6'h00;
      opRead_q <= 1'b0;
      opDc_q   <= 1'b0;
      opByte_q <= 8'h00;
      rspValid <= 1'b0;
      rspByte  <= 8'h00;
    end else begin
      rspValid <= 1'b0;
      if (initGo || userGo) begin
        busy_q   <= 1'b1;
        step_q   <= 6'h00;
        opRead_q <= initGo ? 1'b0 : reqRead;
        opDc_q   <= initGo ? initNow[8] : reqIsData;
        opByte_q <= initGo ? initNow[7:0] : reqByte;
      end else if (busy_q && tick) begin
        step_q <= step_q + 6'h01;
        if (step_q == lastOf(modeSel)) busy_q <= 1'b0;
        if (opRead_q && step_q == 6'h01) begin
          rspValid <= 1'b1;
          rspByte  <= dbB_q;
        end
      end
    end
  end

  logic        csN;
  logic        rwWrN;
  logic        eRdN;
  logic [7:0]  dOut;
  logic [7:0]  dOe;
  logic        scl;
  logic        sda;
  logic [5:0]  sm1;
  logic [5:0]  sm2;
  logic [26:0] frame;
  always_comb begin
    sm1   = step_q - 6'h01;
    sm2   = step_q - 6'h02;
    frame = {I2C_ADDR_BASE[6:1], addrLsbSel, 1'b0, 1'b1, opDc_q ? CTRL_DATA : CTRL_CMD, 1'b1, opByte_q, 1'b1};
    csN   = 1'b1;
    rwWrN = 1'b1;
    eRdN  = 1'b1;
    dOut  = opByte_q;
    dOe   = 8'h00;
    scl   = 1'b1;
    sda   = 1'b1;
    case (modeSel)
      OLHI_P6800: begin
        csN   = !busy_q || step_q == LAST_PAR;
        rwWrN = !busy_q || opRead_q;
        eRdN  = busy_q && step_q == 6'h01;
        dOe   = (busy_q && !opRead_q) ? 8'hFF : 8'h00;
      end
      OLHI_P8080: begin
        csN   = !busy_q || step_q == LAST_PAR;
        rwWrN = !(busy_q && step_q == 6'h01 && !opRead_q);
        eRdN  = !(busy_q && step_q == 6'h01 && opRead_q);
        dOe   = (busy_q && !opRead_q) ? 8'hFF : 8'h00;
      end
      OLHI_SPI: begin
        csN   = !busy_q || step_q == LAST_SPI;
        rwWrN = 1'b0;
        eRdN  = 1'b0;
        scl   = busy_q && step_q != 6'h00 && step_q < LAST_SPI && !step_q[0];
        sda   = opByte_q[~sm1[3:1]];
        dOe   = 8'hFB;
        dOut  = {6'h00, sda, scl};
      end
      default: begin
        csN   = 1'b0;
        rwWrN = 1'b0;
        eRdN  = 1'b0;
        if (busy_q && step_q == 6'h01) begin
          sda = 1'b0;
        end else if (busy_q && step_q > 6'h01 && step_q < 6'h38) begin
          scl = step_q[0];
          sda = frame[5'd26 - sm2[5:1]];
        end else if (busy_q && step_q != 6'h00 && step_q < LAST_I2C) begin
          scl = step_q != 6'h38;
          sda = 1'b0;
        end
        dOe   = {5'h1F, 1'b0, !sda, !scl};
        dOut  = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      link.resetN    <= 1'b0;
      link.csN       <= 1'b1;
      link.dc        <= 1'b0;
      link.rwWrN     <= 1'b1;
      link.eRdN      <= 1'b1;
      link.selHi     <= 1'b0;
      link.selLo     <= 1'b0;
      link.addrLsb   <= 1'b0;
      link.hostDbOut <= 8'h00;
      link.hostDbOe  <= 8'h00;
    end else begin
      link.resetN    <= !devResetReq;
      link.csN       <= csN;
      link.dc        <= modeSel == OLHI_I2C ? 1'b0 : opDc_q;
      link.rwWrN     <= rwWrN;
      link.eRdN      <= eRdN;
      link.selHi     <= modeSel == OLHI_P6800 || modeSel == OLHI_P8080;
      link.selLo     <= modeSel == OLHI_P8080 || modeSel == OLHI_I2C;
      link.addrLsb   <= addrLsbSel;
      link.hostDbOut <= dOut;
      link.hostDbOe  <= dOe;
    end
  end
endmodule // olhi_host

// [tb/olhi_checker.sv]
// Purpose: concurrent checks on the link pins between host and display controller
// Assumes: one clk_sys domain, resetn asynchronous active low
// Notes:   mode pins decoded as {selHi, selLo}
`timescale 1ns/1ns
module olhi_checker import olhi_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       resetN,
  input wire logic       csN,
  input wire logic       dc,
  input wire logic       rwWrN,
  input wire logic       eRdN,
  input wire logic       selHi,
  input wire logic       selLo,
  input wire logic [7:0] hostDbOut,
  input wire logic [7:0] hostDbOe,
  input wire logic [7:0] devDbOe,
  input wire logic [7:0] db
);
  logic       db0_q;
  logic [3:0] spiCnt_q;
  logic       spiMode;
  logic       p6800;
  logic       p8080;
  assign spiMode = !selHi && !selLo;
  assign p6800   = selHi && !selLo;
  assign p8080   = selHi && selLo;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) db0_q <= 1'b0;
    else db0_q <= db[0];
  end

  // serial clock rises seen inside one chip-select frame
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) spiCnt_q <= 4'h0;
    else if (csN) spiCnt_q <= 4'h0;
    else if (db[0] && !db0_q) spiCnt_q <= spiCnt_q + 4'h1;
  end

  sequence s_strobe_high;
    (eRdN && !csN) [*6];
  endsequence

  a_reset_idle: assert property ($rose(resetn) |-> csN && !resetN && hostDbOe == 8'h00 && devDbOe == 8'h00)
    else $error("link not idle after reset release");
  a_no_drive_wr: assert property (selHi && !rwWrN |-> devDbOe == 8'h00)
    else $error("device drives bus during a write");
  a_serial_drive: assert property (!selHi |-> devDbOe == 8'h00 || (selLo && devDbOe == 8'h04))
    else $error("device drives a serial-mode line other than the acknowledge");
  a_dc_stable: assert property (!csN && $past(!csN) && (selHi || !selLo) |-> $stable(dc))
    else $error("command/data select moved inside a transfer");
  a_e_fall_cs: assert property (p6800 && $past(p6800) && !rwWrN && $fell(eRdN) |-> !csN)
    else $error("enable fell without chip select");
  a_wr_rise_cs: assert property (p8080 && $past(p8080) && $rose(rwWrN) |-> !csN)
    else $error("write strobe rose without chip select");
  a_e_high_len: assert property (p6800 && $past(p6800) && $rose(eRdN) |-> s_strobe_high)
    else $error("enable high phase too short or outside chip select");
  a_spi_ties: assert property (spiMode && $past(spiMode) && !csN
                               |-> hostDbOe[7:3] == 5'h1F && hostDbOut[7:3] == 5'h00 && !hostDbOe[2]
                                   && !rwWrN && !eRdN)
    else $error("serial mode unused pins not tied");
  a_spi_eight_clk: assert property (spiMode && $past(spiMode) && $rose(csN) |-> spiCnt_q == 4'h8)
    else $error("serial frame does not hold eight clocks");
endmodule // olhi_checker

// [tb/tb_oled_display_host_interface.sv]
// Purpose: self-checking bench, host end driving device end in every link mode
// Assumes: default link step of HALF_CYC clocks
// Notes:   second host on a link with no device shows acknowledges are not needed
`timescale 1ns/1ns
module tb_oled_display_host_interface import olhi_pkg::*;;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       devResetReq = 1'b0;
  logic       initStart = 1'b0;
  logic       addrLsbSel = 1'b0;
  logic       reqValid = 1'b0;
  logic       reqRead = 1'b0;
  logic       reqIsData = 1'b0;
  logic [7:0] reqByte = 8'h00;
  logic [7:0] statusByte = 8'h96;
  logic [7:0] readByte = 8'h69;
  olhi_mode_t modeSel = OLHI_P6800;
  olhi_mode_t mode;
  logic       initBusy, reqReady, reqReadyB, rspValid, wrValid, wrIsData, rdDone, rdIsData;
  logic [7:0] rspByte, wrByte;
  int         failures = 0;
  int         comparisons = 0;

  olhi_if link();
  olhi_if linkB();
  assign linkB.devDbOe  = 8'h00;
  assign linkB.devDbOut = 8'h00;

  always #5 clk_sys = ~clk_sys;

  olhi_host olhi_host_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link), .modeSel(modeSel),
    .addrLsbSel(addrLsbSel), .devResetReq(devResetReq), .initStart(initStart), .initBusy(initBusy),
    .reqValid(reqValid), .reqRead(reqRead), .reqIsData(reqIsData), .reqByte(reqByte), .reqReady(reqReady),
    .rspValid(rspValid), .rspByte(rspByte));
  olhi_host olhi_host_inst_b (.clk_sys(clk_sys), .resetn(resetn), .link(linkB), .modeSel(modeSel),
    .addrLsbSel(addrLsbSel), .devResetReq(devResetReq), .initStart(initStart), .initBusy(),
    .reqValid(reqValid), .reqRead(reqRead), .reqIsData(reqIsData), .reqByte(reqByte), .reqReady(reqReadyB),
    .rspValid(), .rspByte());
  olhi_device olhi_device_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link), .wrValid(wrValid),
    .wrIsData(wrIsData), .wrByte(wrByte), .rdDone(rdDone), .rdIsData(rdIsData), .statusByte(statusByte),
    .readByte(readByte), .mode(mode));
  olhi_checker olhi_checker_inst (.clk_sys(clk_sys), .resetn(resetn), .resetN(link.resetN), .csN(link.csN),
    .dc(link.dc), .rwWrN(link.rwWrN), .eRdN(link.eRdN), .selHi(link.selHi), .selLo(link.selLo),
    .hostDbOut(link.hostDbOut), .hostDbOe(link.hostDbOe), .devDbOe(link.devDbOe), .db(link.db));

  task automatic results();
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  task automatic send(input logic rd, input logic d, input logic [7:0] b);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqRead <= rd;
    reqIsData <= d;
    reqByte <= b;
    do begin
      @(posedge clk_sys);
      n++;
    end while (reqReady !== 1'b1 && n < 2000);
    reqValid <= 1'b0;
  endtask

  // sel 0 byte written, 1 read done, 2 host response
  task automatic waitEv(input int sel, input int lim);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge clk_sys);
      n++;
      hit = (sel == 0) ? (wrValid === 1'b1) : (sel == 1) ? (rdDone === 1'b1) : (rspValid === 1'b1);
    end
    chk(8'(hit), 8'h01);
  endtask

  task automatic expectWr(input logic d, input logic [7:0] b);
    waitEv(0, 1200);
    chk(8'(wrIsData), 8'(d));
    chk(wrByte, b);
  endtask

  task automatic noEv(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      if (wrValid === 1'b1 || rdDone === 1'b1 || rspValid === 1'b1) seen = 1'b1;
    end
    chk(8'(seen), 8'h00);
  endtask

  task automatic setMode(input olhi_mode_t m);
    waitReady();
    modeSel <= m;
    repeat (6) @(posedge clk_sys);
    chk(8'(mode), 8'(m));
  endtask

  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      setMode(olhi_mode_t'(i));
      send(1'b0, 1'b0, 8'hC1);
      expectWr(1'b0, 8'hC1);
      send(1'b0, 1'b1, 8'h3E);
      expectWr(1'b1, 8'h3E);
    end
  endtask

  task automatic t_reads();
    for (int i = 0; i < 2; i++) begin
      setMode(i == 0 ? OLHI_P6800 : OLHI_P8080);
      for (int d = 0; d < 2; d++) begin
        send(1'b1, 1'(d), 8'h00);
        waitEv(2, 300);
        chk(rspByte, d == 1 ? 8'h69 : 8'h96);
        waitEv(1, 300);
        chk(8'(rdIsData), 8'(d));
      end
    end
  endtask

  task automatic t_nop();
    send(1'b0, 1'b0, NOP_CMD);
    noEv(120);
    send(1'b0, 1'b1, NOP_CMD);
    expectWr(1'b1, NOP_CMD);
  endtask

  task automatic t_serial_read();
    for (int i = 2; i < 4; i++) begin
      setMode(olhi_mode_t'(i));
      send(1'b1, 1'b1, 8'h00);
      noEv(700);
    end
  endtask

  task automatic t_i2c_lsb();
    addrLsbSel <= 1'b1;
    repeat (4) @(posedge clk_sys);
    send(1'b0, 1'b1, 8'hA7);
    expectWr(1'b1, 8'hA7);
    waitReady();
    chk(8'(reqReadyB), 8'h01);
  endtask

  task automatic t_pin_reset();
    setMode(OLHI_SPI);
    send(1'b0, 1'b1, 8'hC3);
    repeat (60) @(posedge clk_sys);
    devResetReq <= 1'b1;
    repeat (8) @(posedge clk_sys);
    devResetReq <= 1'b0;
    noEv(200);
    send(1'b0, 1'b1, 8'h81);
    expectWr(1'b1, 8'h81);
  endtask

  task automatic t_init();
    logic [7:0] cmds [7];
    cmds = '{CMD_DISP_OFF, CMD_MUX, MUX_32, CMD_PRECHG, PRECHG_VAL, CMD_ADDR_MODE, ADDR_HORIZ};
    setMode(OLHI_P6800);
    initStart <= 1'b1;
    @(posedge clk_sys);
    initStart <= 1'b0;
    for (int i = 0; i < 7; i++) expectWr(1'b0, cmds[i]);
    for (int i = 0; i < 512; i++) expectWr(1'b1, 8'h00);
    expectWr(1'b0, CMD_DISP_ON);
    repeat (60) @(posedge clk_sys);
    chk(8'(initBusy), 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_modes();
    t_reads();
    t_nop();
    t_serial_read();
    t_i2c_lsb();
    t_pin_reset();
    t_init();
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    send(1'b0, 1'b0, 8'h42);
    expectWr(1'b0, 8'h42);
    results();
  end

  // cut a hang well beyond the expected run length
  initial begin
    #800000;
    failures++;
    results();
  end
endmodule // tb_oled_display_host_interface
